// file: logic/ctr_map.vh
// Offsets, field positions, reset values and current figures for the charger registers
// Notes on behaviour
// RULE1 - Thermal register resets to 1xxx 1000
// RULE2 - Bit 7 clear turns thermistor sensing off
// RULE3 - Bits 6..5 report live thermal fault code
// RULE4 - Reporting enable low: interrupt shows faults only; code still interrupts on wake, reset and timer events unless masked
// RULE5 - Reporting enable high: faults and status changes
// RULE6 - Bit 2 masks push-button wake interrupt
// RULE7 - Bit 1 masks reset interrupt, not reset output
// RULE8 - Bit 0 masks safety-timer fault interrupt
// RULE9 - Fast-charge register read/write, resets to 0x14
// RULE10 - Low range: 5 mA plus code mA
// RULE11 - High range: 40 mA plus code times 10
// RULE12 - Code in bits 6..2, binary weighted
// RULE13 - Over-range current saturates at range maximum
// RULE14 - All-ones code selects external set resistor
// RULE15 - Host programs termination code before all-ones
// RULE16 - Host loads termination code for chosen percentage
// RULE17 - Fast-charge bit 1 set disables charger
// RULE18 - Fast-charge bit 0 set selects high impedance
// RULE19 - Unimplemented address reads back 0xff
// RULE20 - Writes to bits 6..4 are ignored
// RULE21 - Masked events still update their status flags
`ifndef CTR_MAP_VH
`define CTR_MAP_VH
`define CTR_ADDR_THERMAL 8'h02
`define CTR_ADDR_FAST 8'h03
`define CTR_THERMAL_RESET 8'h88
`define CTR_FAST_RESET 8'h14
`define CTR_UNMAPPED_READ 8'hff
`define CTR_BIT_THERMISTOR_SENSE_ENABLE 7
`define CTR_BIT_FAULT_HI 6
`define CTR_BIT_FAULT_LO 5
`define CTR_BIT_REPORT_EN 3
`define CTR_BIT_WAKE_M 2
`define CTR_BIT_RESET_M 1
`define CTR_BIT_TIMER_M 0
`define CTR_BIT_RANGE 7
`define CTR_CODE_HI 6
`define CTR_CODE_LO 2
`define CTR_BIT_DISABLE 1
`define CTR_BIT_HIZ 0
`define CTR_CODE_EXTERNAL 5'h1f
`define CTR_LOW_BASE_MA 9'h005
`define CTR_LOW_STEP_MA 9'h001
`define CTR_LOW_MAX_MA 9'h023
`define CTR_HIGH_BASE_MA 9'h028
`define CTR_HIGH_STEP_MA 9'h00a
`define CTR_HIGH_MAX_MA 9'h12c
`define CTR_EV_WAKE 0
`define CTR_EV_PB_RESET 1
`define CTR_EV_TIMER 2
`define CTR_EV_FAULT 3
`define CTR_EV_STATUS 4
`endif

// file: logic/ctr_regs.v
// Thermal-control and fast-charge control registers with interrupt gating
`timescale 1ns/1ps
`include "ctr_map.vh"
module ctr_regs #(
   parameter EVENTS = 5
)(
   input wire CLOCK_IN,
   input wire RESET_IN,
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire REG_WRITE_IN,
   input wire REG_READ_IN,
   output reg [7:0] REG_RDATA_OUT,
   output reg REG_RVALID_OUT,
   input wire [1:0] THERMAL_FAULT_CODE_IN,
   input wire [EVENTS-1:0] EVENT_IN,
   output reg THERMISTOR_SENSE_ENABLE_OUT,
   output reg INTERRUPT_OUT,
   output reg PUSH_BUTTON_RESET_OUT,
   output reg [EVENTS-1:0] EVENT_FLAGS_OUT,
   output reg [8:0] CHARGE_CURRENT_MA_OUT,
   output reg USE_EXTERNAL_SET_OUT,
   output reg CHARGER_DISABLE_OUT,
   output reg HIGH_IMPEDANCE_SELECT_OUT
);
   reg [7:0] thermal_ctrl;
   reg [7:0] fast_ctrl;
   reg [1:0] fault_meta;
   reg [1:0] fault_sync;
   reg [1:0] fault_prev;
   reg [1:0] fault_code;
   reg [EVENTS-1:0] ev_meta;
   reg [EVENTS-1:0] ev_sync;
   reg [EVENTS-1:0] ev_prev;
   wire [EVENTS-1:0] ev_rise;
   wire [EVENTS-1:0] ev_enable;
   wire [4:0] code;
   wire range_high;
   reg [8:0] next_current;
   reg [8:0] raw_current;
   reg [7:0] next_rdata;
   wire hit_thermal;
   wire hit_fast;

   assign hit_thermal = (REG_ADDR_IN == `CTR_ADDR_THERMAL);
   assign hit_fast = (REG_ADDR_IN == `CTR_ADDR_FAST);
   // RULE12 code bit field
   assign code = fast_ctrl[`CTR_CODE_HI:`CTR_CODE_LO];
   assign range_high = fast_ctrl[`CTR_BIT_RANGE];

   // Two flops: fault code and events come from the analog side
   always @(posedge CLOCK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         fault_meta <= 2'h0;
         fault_sync <= 2'h0;
         ev_meta <= {EVENTS{1'b0}};
         ev_sync <= {EVENTS{1'b0}};
         ev_prev <= {EVENTS{1'b0}};
      end
      else
      begin
         fault_meta <= THERMAL_FAULT_CODE_IN;
         fault_sync <= fault_meta;
         ev_meta <= EVENT_IN;
         ev_sync <= ev_meta;
         ev_prev <= ev_sync;
      end
   end

   // Fault code is a two-bit word; a skewed change could read as a false code
   // Take it only once two samples in a row agree, at one cycle of extra lag
   always @(posedge CLOCK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         fault_prev <= 2'h0;
         fault_code <= 2'h0;
      end
      else
      begin
         fault_prev <= fault_sync;
         if (fault_sync == fault_prev)
         begin
            fault_code <= fault_sync;
         end
      end
   end

   // Per-event gating; each event counts once on its rising edge
   genvar i;
   generate
      for (i = 0; i < EVENTS; i = i + 1)
      begin : g_ev
         assign ev_rise[i] = ev_sync[i] & ~ev_prev[i];
         if (i == `CTR_EV_WAKE)
         begin : g_wake
            // RULE6 wake mask
            assign ev_enable[i] = ~thermal_ctrl[`CTR_BIT_WAKE_M];
         end
         else if (i == `CTR_EV_PB_RESET)
         begin : g_rst
            // RULE7 reset irq mask
            assign ev_enable[i] = ~thermal_ctrl[`CTR_BIT_RESET_M];
         end
         else if (i == `CTR_EV_TIMER)
         begin : g_tmr
            // RULE8 timer mask
            assign ev_enable[i] = ~thermal_ctrl[`CTR_BIT_TIMER_M];
         end
         else if (i == `CTR_EV_STATUS)
         begin : g_sts
            // RULE4 RULE5 status reporting gate
            assign ev_enable[i] = thermal_ctrl[`CTR_BIT_REPORT_EN];
         end
         else
         begin : g_flt
            assign ev_enable[i] = 1'b1;
         end
      end
   endgenerate

   // Effective charge current
   always @*
   begin
      raw_current = 9'h000;
      next_current = 9'h000;
      if (range_high)
      begin
         // RULE11 high range
         raw_current = `CTR_HIGH_BASE_MA + `CTR_HIGH_STEP_MA * {4'h0, code};
         // RULE13 saturate high
         next_current = (raw_current > `CTR_HIGH_MAX_MA) ? `CTR_HIGH_MAX_MA : raw_current;
      end
      else
      begin
         // RULE10 low range
         raw_current = `CTR_LOW_BASE_MA + `CTR_LOW_STEP_MA * {4'h0, code};
         // RULE13 saturate low
         next_current = (raw_current > `CTR_LOW_MAX_MA) ? `CTR_LOW_MAX_MA : raw_current;
      end
   end

   // Read data; reserved bit 4 reads zero
   always @*
   begin
      next_rdata = `CTR_UNMAPPED_READ;
      if (hit_thermal)
      begin
         // RULE3 live fault code
         next_rdata = {thermal_ctrl[7], fault_code, 1'b0, thermal_ctrl[3:0]};
      end
      else if (hit_fast)
      begin
         next_rdata = fast_ctrl;
      end
      else
      begin
         // RULE19 unmapped reads all ones
         next_rdata = `CTR_UNMAPPED_READ;
      end
   end

   always @(posedge CLOCK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         // RULE1 thermal reset value
         thermal_ctrl <= `CTR_THERMAL_RESET;
         // RULE9 fast-charge reset value
         fast_ctrl <= `CTR_FAST_RESET;
         REG_RDATA_OUT <= 8'h00;
         REG_RVALID_OUT <= 1'b0;
      end
      else
      begin
         if (REG_WRITE_IN && hit_thermal)
         begin
            // RULE20 read-only bits stored as zero
            thermal_ctrl <= {REG_WDATA_IN[7], 3'h0, REG_WDATA_IN[3:0]};
         end
         if (REG_WRITE_IN && hit_fast)
         begin
            // RULE9 full read/write
            fast_ctrl <= REG_WDATA_IN;
         end
         REG_RVALID_OUT <= REG_READ_IN;
         if (REG_READ_IN)
         begin
            REG_RDATA_OUT <= next_rdata;
         end
      end
   end

   // Registered outputs; one cycle behind the control registers and event edges
   always @(posedge CLOCK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         THERMISTOR_SENSE_ENABLE_OUT <= 1'b1;
         INTERRUPT_OUT <= 1'b0;
         PUSH_BUTTON_RESET_OUT <= 1'b0;
         EVENT_FLAGS_OUT <= {EVENTS{1'b0}};
         CHARGE_CURRENT_MA_OUT <= `CTR_LOW_BASE_MA;
         USE_EXTERNAL_SET_OUT <= 1'b0;
         CHARGER_DISABLE_OUT <= 1'b0;
         HIGH_IMPEDANCE_SELECT_OUT <= 1'b0;
      end
      else
      begin
         // RULE2 sensing enable
         THERMISTOR_SENSE_ENABLE_OUT <= thermal_ctrl[`CTR_BIT_THERMISTOR_SENSE_ENABLE];
         // RULE21 flags ignore masks
         EVENT_FLAGS_OUT <= ev_rise;
         INTERRUPT_OUT <= |(ev_rise & ev_enable);
         // RULE7 reset output unmasked
         PUSH_BUTTON_RESET_OUT <= ev_rise[`CTR_EV_PB_RESET];
         // RULE14 external set code
         USE_EXTERNAL_SET_OUT <= (code == `CTR_CODE_EXTERNAL);
         CHARGE_CURRENT_MA_OUT <= next_current;
         // RULE17 charger disable
         CHARGER_DISABLE_OUT <= fast_ctrl[`CTR_BIT_DISABLE];
         // RULE18 high impedance
         HIGH_IMPEDANCE_SELECT_OUT <= fast_ctrl[`CTR_BIT_HIZ];
      end
   end
endmodule // ctr_regs

// file: verif/ctr_regs_chk.sv
// Port assertions for the charger register block
`timescale 1ns/1ps
module ctr_regs_chk (
   input wire CLOCK_IN,
   input wire RESET_IN,
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire REG_WRITE_IN,
   input wire REG_READ_IN,
   input wire [7:0] REG_RDATA_OUT,
   input wire [4:0] EVENT_IN,
   input wire THERMISTOR_SENSE_ENABLE_OUT,
   input wire INTERRUPT_OUT,
   input wire PUSH_BUTTON_RESET_OUT,
   input wire [4:0] EVENT_FLAGS_OUT,
   input wire USE_EXTERNAL_SET_OUT,
   input wire CHARGER_DISABLE_OUT,
   input wire HIGH_IMPEDANCE_SELECT_OUT
);
   wire wr_fast = REG_WRITE_IN && REG_ADDR_IN == 8'h03;
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (RESET_IN);
   bad_addr_a: assert property (REG_READ_IN && REG_ADDR_IN[7:1] != 7'h01
      |=> REG_RDATA_OUT == 8'hff) else $error("unmapped read wrong");
   ce_hiz_a: assert property (wr_fast |-> ##2
      {CHARGER_DISABLE_OUT, HIGH_IMPEDANCE_SELECT_OUT} == $past(REG_WDATA_IN[1:0], 2))
      else $error("disable or hiz wrong");
   sense_wr_a: assert property (REG_WRITE_IN && REG_ADDR_IN == 8'h02 |-> ##2
      THERMISTOR_SENSE_ENABLE_OUT == $past(REG_WDATA_IN[7], 2)) else $error("sense wrong");
   ext_sel_a: assert property (wr_fast |-> ##2
      USE_EXTERNAL_SET_OUT == ($past(REG_WDATA_IN[6:2], 2) == 5'h1f)) else $error("ext wrong");
   pb_rst_a: assert property ($rose(EVENT_IN[1]) |-> ##3 PUSH_BUTTON_RESET_OUT)
      else $error("reset output missing");
   timer_flag_a: assert property ($rose(EVENT_IN[2]) |-> ##3 EVENT_FLAGS_OUT[2])
      else $error("timer flag missing");
   fault_irq_a: assert property ($rose(EVENT_IN[3]) |-> ##3 INTERRUPT_OUT)
      else $error("fault interrupt missing");
   irq_cause_a: assert property (INTERRUPT_OUT |-> |EVENT_FLAGS_OUT)
      else $error("interrupt without event");
   cover property (INTERRUPT_OUT);
   cover property (USE_EXTERNAL_SET_OUT);
   cover property (PUSH_BUTTON_RESET_OUT);
endmodule // ctr_regs_chk
bind ctr_regs ctr_regs_chk ctr_regs_chk_inst (.*);

// file: verif/ctr_host.sv
// Host-side register access model
`timescale 1ns/1ps
module ctr_host (
   input wire clk_in,
   input wire rv_in,
   input wire [7:0] rdat_in,
   output reg [7:0] addr_out,
   output reg [7:0] wdat_out,
   output reg wr_out,
   output reg rd_out
);
   initial {addr_out, wdat_out, wr_out, rd_out} = 18'h0;
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clk_in) {addr_out, wdat_out, wr_out} = {a, d, 1'b1};
      @(negedge clk_in) {wdat_out, wr_out} = {~d, 1'b0};
   endtask
   // Answer is fixed at one cycle, so no polling
   task rd(input [7:0] a, output [7:0] d, output ok);
      @(negedge clk_in) {addr_out, rd_out} = {a, 1'b1};
      @(negedge clk_in) rd_out = 1'b0;
      {ok, d} = {rv_in, rdat_in};
   endtask
endmodule // ctr_host

// file: verif/ctr_regs_bench.sv
// Self-checking bench for the charger registers
`timescale 1ns/1ps
module ctr_regs_bench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [1:0] fault = 2'h0;
   reg [4:0] ev = 5'h0;
   wire [7:0] addr, wdata, rdata;
   wire wr_s, rd_s, rvalid, sense, irq, pbr, ext, dis, hiz;
   wire [4:0] flags;
   wire [8:0] cur;
   integer error_cnt = 0;
   integer n_checks = 0;
   integer i, m;
   always #4 clk = ~clk;
   ctr_host ctr_host_inst (.clk_in(clk), .rv_in(rvalid), .rdat_in(rdata), .addr_out(addr),
      .wdat_out(wdata), .wr_out(wr_s), .rd_out(rd_s));
   ctr_regs ctr_regs_inst (.CLOCK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr_s), .REG_READ_IN(rd_s), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .THERMAL_FAULT_CODE_IN(fault), .EVENT_IN(ev),
      .THERMISTOR_SENSE_ENABLE_OUT(sense), .INTERRUPT_OUT(irq), .PUSH_BUTTON_RESET_OUT(pbr),
      .EVENT_FLAGS_OUT(flags), .CHARGE_CURRENT_MA_OUT(cur), .USE_EXTERNAL_SET_OUT(ext),
      .CHARGER_DISABLE_OUT(dis), .HIGH_IMPEDANCE_SELECT_OUT(hiz));
   task results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input [11:0] got, input [11:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] exp);
      reg [7:0] d;
      reg ok;
      ctr_host_inst.rd(a, d, ok);
      chk({3'h0, ok, d}, {4'h1, exp});
   endtask
   task ev_chk(input integer b, input exp_i);
      integer k;
      reg [3:0] ni, nf, np;
      {ni, nf, np} = 12'h000;
      ev[b] = 1'b1;
      for (k = 0; k < 8; k = k + 1)
      begin
         @(negedge clk);
         ev[b] = k < 3;
         ni = ni + irq;
         nf = nf + flags[b];
         np = np + pbr;
      end
      chk({ni, nf, np}, {3'h0, exp_i, 4'h1, 3'h0, b == 1});
   endtask
   task t_reset;
      rd_chk(8'h02, 8'h88);
      rd_chk(8'h03, 8'h14);
      chk({sense, dis, hiz, cur}, {3'h4, 9'h00a});
   endtask
   task t_cur;
      reg [4:0] c;
      reg r;
      reg [8:0] e;
      for (i = 0; i < 62; i = i + 1)
      begin
         c = 5'(i % 31);
         r = 1'(i / 31);
         e = r ? 9'h028 + 9'h00a * c : 9'h005 + c;
         if (e > 9'h12c) e = 9'h12c;
         ctr_host_inst.wr(8'h03, {r, c, 2'h0});
         @(negedge clk);
         chk({sense, dis, hiz, cur}, {3'h4, e});
      end
      ctr_host_inst.wr(8'h04, 8'h01);
      ctr_host_inst.wr(8'h03, 8'h7f);
      @(negedge clk);
      chk({9'h000, ext, dis, hiz}, 12'h007);
      rd_chk(8'h03, 8'h7f);
      rd_chk(8'h04, 8'hff);
   endtask
   task t_ro;
      ctr_host_inst.wr(8'h02, 8'h70);
      for (i = 0; i < 4; i = i + 1)
      begin
         fault = 2'(i);
         repeat (4) @(negedge clk);
         rd_chk(8'h02, {1'b0, fault, 5'h00});
      end
      chk({11'h000, sense}, 12'h000);
   endtask
   task t_irq;
      for (m = 0; m < 4; m = m + 1)
      begin
         ctr_host_inst.wr(8'h02, m == 3 ? 8'h00 : 8'h08 | 8'(1 << m));
         for (i = 0; i < 5; i = i + 1)
            ev_chk(i, m == 3 ? i != 4 : i != 2 - m);
      end
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset;
      t_cur;
      t_ro;
      t_irq;
      results;
   end
endmodule // ctr_regs_bench
